//--- logic/bsc_pkg.sv
package bsc_pkg;

    // scan chain geometry
    localparam int IR_LEN = 10;
    localparam int ID_LEN = 32;
    localparam int BSR_LEN_DEF = 192;
    localparam int CELLS_PER_PIN = 3;
    localparam int ISP_LEN_DEF = 32;

    // boundary cell order inside one pin group
    localparam int CELL_IN = 0;
    localparam int CELL_OUT = 1;
    localparam int CELL_OE = 2;

    // value loaded into the instruction shifter on capture-ir
    localparam logic [9:0] IR_CAPTURE_VAL = 10'h001;

    // default opcodes, overridable per instance
    localparam logic [9:0] OP_EXTEST_DEF = 10'h000;
    localparam logic [9:0] OP_SAMPLE_DEF = 10'h005;
    localparam logic [9:0] OP_IDCODE_DEF = 10'h006;
    localparam logic [9:0] OP_USERCODE_DEF = 10'h007;
    localparam logic [9:0] OP_BYPASS_DEF = 10'h3ff;
    localparam logic [9:0] ISP_OP_BASE_DEF = 10'h200;
    localparam logic [9:0] ISP_OP_MASK_DEF = 10'h300;

    // identification fields; values are arbitrary
    localparam logic [3:0] ID_VERSION_DEF = 4'h3;
    localparam logic [15:0] ID_PART_DEF = 16'h5a5a;
    localparam logic [10:0] ID_MAKER_DEF = 11'h155;
    localparam logic ID_LSB = 1'h1;

    typedef enum logic [3:0] {
        ST_TLR, ST_RTI,
        ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR, ST_EX2_DR, ST_UPD_DR,
        ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
    } bsc_tap_state_t;

    typedef enum logic [2:0] {
        SEL_BYPASS, SEL_BOUNDARY, SEL_IDCODE, SEL_USERCODE, SEL_ISP
    } bsc_dr_sel_t;

endpackage

//--- logic/bsc_tap_if.sv
`timescale 1ns/100ps
interface bsc_tap_if;
    logic reset_state;
    logic capture_dr;
    logic shift_dr;
    logic update_dr;
    logic capture_ir;
    logic shift_ir;
    logic update_ir;

    modport ctl (
        output reset_state, capture_dr, shift_dr, update_dr,
        output capture_ir, shift_ir, update_ir
    );
    modport dp (
        input reset_state, capture_dr, shift_dr, update_dr,
        input capture_ir, shift_ir, update_ir
    );
endinterface

//--- logic/bsc_tap_fsm.sv
`timescale 1ns/100ps
module bsc_tap_fsm (
    // link clock and held reset
    input wire logic tck,
    input wire logic tap_rst,
    // mode select from the link
    input wire logic tms,
    // decoded controller states
    bsc_tap_if.ctl tap
);
    import bsc_pkg::*;

    typedef struct packed {
        bsc_tap_state_t state;
    } bsc_fsm_st_t;

    bsc_fsm_st_t st_reg;
    bsc_fsm_st_t st_next;

    always_comb
    begin
        st_next = st_reg;
        case (st_reg.state)
            ST_TLR: st_next.state = tms ? ST_TLR : ST_RTI;
            ST_RTI: st_next.state = tms ? ST_SEL_DR : ST_RTI;
            ST_SEL_DR: st_next.state = tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: st_next.state = tms ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR: st_next.state = tms ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: st_next.state = tms ? ST_UPD_DR : ST_PAU_DR;
            ST_PAU_DR: st_next.state = tms ? ST_EX2_DR : ST_PAU_DR;
            ST_EX2_DR: st_next.state = tms ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: st_next.state = tms ? ST_SEL_DR : ST_RTI;
            ST_SEL_IR: st_next.state = tms ? ST_TLR : ST_CAP_IR;
            ST_CAP_IR: st_next.state = tms ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR: st_next.state = tms ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: st_next.state = tms ? ST_UPD_IR : ST_PAU_IR;
            ST_PAU_IR: st_next.state = tms ? ST_EX2_IR : ST_PAU_IR;
            ST_EX2_IR: st_next.state = tms ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: st_next.state = tms ? ST_SEL_DR : ST_RTI;
            default: st_next.state = ST_TLR;
        endcase
        if (tap_rst)
        begin
            st_next.state = ST_TLR;
        end
    end

    always_ff @(posedge tck)
    begin
        st_reg <= st_next;
    end

    // decoded from the state flop, so glitch-free within a tck period
    assign tap.reset_state = (st_reg.state == ST_TLR);
    assign tap.capture_dr = (st_reg.state == ST_CAP_DR);
    assign tap.shift_dr = (st_reg.state == ST_SH_DR);
    assign tap.update_dr = (st_reg.state == ST_UPD_DR);
    assign tap.capture_ir = (st_reg.state == ST_CAP_IR);
    assign tap.shift_ir = (st_reg.state == ST_SH_IR);
    assign tap.update_ir = (st_reg.state == ST_UPD_IR);

endmodule

//--- logic/bsc_tap_top.sv
// What this block does
// - Provides a test access port with the standard sixteen-state controller and boundary-scan circuitry.
// - The instruction register is 10 bits; a scan of 10 or more bits keeps the last 10 bits shifted in.
// - Sample/preload captures pin states without disturbing the core and preloads a shifted pattern.
// - Extest drives output pins from the boundary update stage and captures input pin levels.
// - Bypass puts one flip-flop between tdi and tdo, giving one tck of delay.
// - Idcode puts the identification register between tdi and tdo for serial readout.
// - Usercode puts a 32-bit user code register between tdi and tdo and shifts its programmed value out.
// - Identification and user code registers are each exactly 32 bits.
// - The boundary register length is a per-size parameter, 192 cells by default.
// - The identification value is version, part number, maker field and a final lsb, msb first.
// - Bit 0 of the identification value is always one.
// - When the port is not enabled its pins are released as ordinary user pins.
// - Extra in-system programming instructions are accepted and handed to the programming engine.
`timescale 1ns/100ps
module bsc_tap_top #(
    parameter int BSR_LEN = bsc_pkg::BSR_LEN_DEF,
    parameter int ISP_LEN = bsc_pkg::ISP_LEN_DEF,
    parameter logic [bsc_pkg::IR_LEN-1:0] OP_EXTEST = bsc_pkg::OP_EXTEST_DEF,
    parameter logic [bsc_pkg::IR_LEN-1:0] OP_SAMPLE = bsc_pkg::OP_SAMPLE_DEF,
    parameter logic [bsc_pkg::IR_LEN-1:0] OP_IDCODE = bsc_pkg::OP_IDCODE_DEF,
    parameter logic [bsc_pkg::IR_LEN-1:0] OP_USERCODE = bsc_pkg::OP_USERCODE_DEF,
    parameter logic [bsc_pkg::IR_LEN-1:0] OP_BYPASS = bsc_pkg::OP_BYPASS_DEF,
    parameter logic [bsc_pkg::IR_LEN-1:0] ISP_OP_BASE = bsc_pkg::ISP_OP_BASE_DEF,
    parameter logic [bsc_pkg::IR_LEN-1:0] ISP_OP_MASK = bsc_pkg::ISP_OP_MASK_DEF,
    parameter logic [3:0] ID_VERSION = bsc_pkg::ID_VERSION_DEF,
    parameter logic [15:0] ID_PART = bsc_pkg::ID_PART_DEF,
    parameter logic [10:0] ID_MAKER = bsc_pkg::ID_MAKER_DEF
) (
    // system clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // test port pins
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe,
    // port release and user use of the port pins
    input wire logic tap_enable,
    input wire logic user_tdo_out,
    input wire logic user_tdo_oe,
    output logic user_tck_in,
    output logic user_tms_in,
    output logic user_tdi_in,
    // core side of the scanned pins
    input wire logic [BSR_LEN/bsc_pkg::CELLS_PER_PIN-1:0] core_out,
    input wire logic [BSR_LEN/bsc_pkg::CELLS_PER_PIN-1:0] core_oe,
    output logic [BSR_LEN/bsc_pkg::CELLS_PER_PIN-1:0] core_in,
    // scanned pins
    input wire logic [BSR_LEN/bsc_pkg::CELLS_PER_PIN-1:0] pin_in,
    output logic [BSR_LEN/bsc_pkg::CELLS_PER_PIN-1:0] pin_out,
    output logic [BSR_LEN/bsc_pkg::CELLS_PER_PIN-1:0] pin_oe,
    // nonvolatile configuration values
    input wire logic [bsc_pkg::ID_LEN-1:0] usercode_value,
    input wire logic [ISP_LEN-1:0] isp_rdata,
    // programming engine handoff
    output logic isp_active,
    output logic isp_strobe,
    output logic [bsc_pkg::IR_LEN-1:0] isp_opcode,
    output logic [ISP_LEN-1:0] isp_wdata
);
    import bsc_pkg::*;

    localparam int NPIN = BSR_LEN / CELLS_PER_PIN;
    localparam logic [ID_LEN-1:0] ID_VALUE = {ID_VERSION, ID_PART, ID_MAKER, ID_LSB};

    typedef struct packed {
        logic [1:0] rst_sync;
        logic [1:0] en_sync;
        logic [NPIN-1:0] pin_s1;
        logic [NPIN-1:0] pin_s2;
        logic [NPIN-1:0] cout_s1;
        logic [NPIN-1:0] cout_s2;
        logic [NPIN-1:0] coe_s1;
        logic [NPIN-1:0] coe_s2;
        logic [ID_LEN-1:0] user_s1;
        logic [ID_LEN-1:0] user_s2;
        logic [ISP_LEN-1:0] isp_s1;
        logic [ISP_LEN-1:0] isp_s2;
        logic [IR_LEN-1:0] ir_sr;
        logic [IR_LEN-1:0] ir;
        logic byp;
        logic [BSR_LEN-1:0] dr_sr;
        logic [NPIN-1:0] upd_out;
        logic [NPIN-1:0] upd_oe;
        logic upd_tgl;
        logic isp_tgl;
        logic [ISP_LEN-1:0] isp_hold;
        logic extest_q;
        logic isp_q;
    } bsc_tck_st_t;

    typedef struct packed {
        logic [NPIN-1:0] pin_s1;
        logic [NPIN-1:0] pin_s2;
        logic [2:0] usr_s1;
        logic [2:0] usr_s2;
        logic [2:0] upd_sync;
        logic [2:0] isp_sync;
        logic [1:0] ext_sync;
        logic [1:0] act_sync;
        logic [1:0] en_sync;
        logic [NPIN-1:0] upd_out;
        logic [NPIN-1:0] upd_oe;
        logic [NPIN-1:0] pin_out;
        logic [NPIN-1:0] pin_oe;
        logic isp_strobe;
        logic [IR_LEN-1:0] isp_op;
        logic [ISP_LEN-1:0] isp_data;
    } bsc_mclk_st_t;

    bsc_tck_st_t t_reg;
    bsc_tck_st_t t_next;
    bsc_mclk_st_t m_reg;
    bsc_mclk_st_t m_next;
    logic tap_rst;
    logic extest_t;
    logic isp_sel_t;
    logic tdo_comb;
    logic tdo_neg_reg;
    logic tdo_oe_neg_reg;
    bsc_dr_sel_t dr_sel;

    bsc_tap_if tap ();

    bsc_tap_fsm u_fsm (
        .tck(tck),
        .tap_rst(tap_rst),
        .tms(tms),
        .tap(tap.ctl)
    );

    function automatic bsc_dr_sel_t decode_dr(input logic [IR_LEN-1:0] op);
        if (op == OP_EXTEST || op == OP_SAMPLE)
            return SEL_BOUNDARY;
        else if (op == OP_IDCODE)
            return SEL_IDCODE;
        else if (op == OP_USERCODE)
            return SEL_USERCODE;
        else if ((op & ISP_OP_MASK) == ISP_OP_BASE)
            return SEL_ISP;
        else
            return SEL_BYPASS;
    endfunction

    // tap logic is held in reset while the port pins belong to the user
    assign tap_rst = !t_reg.rst_sync[1] || !t_reg.en_sync[1];
    assign dr_sel = decode_dr(t_reg.ir);
    assign extest_t = t_reg.extest_q;
    assign isp_sel_t = (dr_sel == SEL_ISP);

    // link-clock domain
    always_comb
    begin
        t_next = t_reg;
        t_next.rst_sync = {t_reg.rst_sync[0], rst_n};
        t_next.en_sync = {t_reg.en_sync[0], tap_enable};
        // snapshot paths; the capture reads only the second stage
        t_next.pin_s1 = pin_in;
        t_next.pin_s2 = t_reg.pin_s1;
        t_next.cout_s1 = core_out;
        t_next.cout_s2 = t_reg.cout_s1;
        t_next.coe_s1 = core_oe;
        t_next.coe_s2 = t_reg.coe_s1;
        t_next.user_s1 = usercode_value;
        t_next.user_s2 = t_reg.user_s1;
        t_next.isp_s1 = isp_rdata;
        t_next.isp_s2 = t_reg.isp_s1;

        if (tap.capture_ir)
        begin
            t_next.ir_sr = IR_CAPTURE_VAL;
        end
        else if (tap.shift_ir)
        begin
            t_next.ir_sr = {tdi, t_reg.ir_sr[IR_LEN-1:1]};
        end
        if (tap.update_ir)
        begin
            t_next.ir = t_reg.ir_sr;
        end

        if (tap.capture_dr)
        begin
            t_next.byp = 1'h0;
            case (dr_sel)
                SEL_BOUNDARY:
                begin
                    for (int k = 0; k < NPIN; k++)
                    begin
                        t_next.dr_sr[CELLS_PER_PIN*k+CELL_IN] = t_reg.pin_s2[k];
                        t_next.dr_sr[CELLS_PER_PIN*k+CELL_OUT] = t_reg.cout_s2[k];
                        t_next.dr_sr[CELLS_PER_PIN*k+CELL_OE] = t_reg.coe_s2[k];
                    end
                end
                SEL_IDCODE: t_next.dr_sr[ID_LEN-1:0] = ID_VALUE;
                SEL_USERCODE: t_next.dr_sr[ID_LEN-1:0] = t_reg.user_s2;
                SEL_ISP: t_next.dr_sr[ISP_LEN-1:0] = t_reg.isp_s2;
                default: t_next.dr_sr = t_reg.dr_sr;
            endcase
        end
        else if (tap.shift_dr)
        begin
            t_next.byp = tdi;
            t_next.dr_sr = {1'h0, t_reg.dr_sr[BSR_LEN-1:1]};
            case (dr_sel)
                SEL_BOUNDARY: t_next.dr_sr[BSR_LEN-1] = tdi;
                SEL_IDCODE: t_next.dr_sr[ID_LEN-1] = tdi;
                SEL_USERCODE: t_next.dr_sr[ID_LEN-1] = tdi;
                SEL_ISP: t_next.dr_sr[ISP_LEN-1] = tdi;
                default: t_next.dr_sr = t_reg.dr_sr;
            endcase
        end

        if (tap.update_dr && dr_sel == SEL_BOUNDARY)
        begin
            for (int k = 0; k < NPIN; k++)
            begin
                t_next.upd_out[k] = t_reg.dr_sr[CELLS_PER_PIN*k+CELL_OUT];
                t_next.upd_oe[k] = t_reg.dr_sr[CELLS_PER_PIN*k+CELL_OE];
            end
            t_next.upd_tgl = !t_reg.upd_tgl;
        end
        if (tap.update_dr && isp_sel_t)
        begin
            t_next.isp_hold = t_reg.dr_sr[ISP_LEN-1:0];
            t_next.isp_tgl = !t_reg.isp_tgl;
        end

        if (tap_rst || tap.reset_state)
        begin
            t_next.ir = OP_IDCODE;
            t_next.ir_sr = IR_CAPTURE_VAL;
            t_next.byp = 1'h0;
        end
        if (tap_rst)
        begin
            t_next.dr_sr = '0;
            t_next.upd_out = '0;
            t_next.upd_oe = '0;
            t_next.upd_tgl = 1'h0;
            t_next.isp_tgl = 1'h0;
            t_next.isp_hold = '0;
        end
        // mode levels leave this domain from flops, so no decode glitch is synchronised
        t_next.extest_q = (t_next.ir == OP_EXTEST);
        t_next.isp_q = (decode_dr(t_next.ir) == SEL_ISP);
    end

    always_ff @(posedge tck)
    begin
        t_reg <= t_next;
    end

    always_comb
    begin
        tdo_comb = 1'h0;
        if (tap.shift_ir)
            tdo_comb = t_reg.ir_sr[0];
        else if (dr_sel == SEL_BYPASS)
            tdo_comb = t_reg.byp;
        else
            tdo_comb = t_reg.dr_sr[0];
    end

    // tdo moves on the falling edge so the far end samples mid-period
    always_ff @(negedge tck)
    begin
        if (tap_rst)
        begin
            tdo_neg_reg <= 1'h0;
            tdo_oe_neg_reg <= 1'h0;
        end
        else
        begin
            tdo_neg_reg <= tdo_comb;
            tdo_oe_neg_reg <= tap.shift_ir || tap.shift_dr;
        end
    end

    // system clock domain
    always_comb
    begin
        m_next = m_reg;
        m_next.pin_s1 = pin_in;
        m_next.pin_s2 = m_reg.pin_s1;
        m_next.usr_s1 = {tck, tms, tdi};
        m_next.usr_s2 = m_reg.usr_s1;
        m_next.upd_sync = {m_reg.upd_sync[1:0], t_reg.upd_tgl};
        m_next.isp_sync = {m_reg.isp_sync[1:0], t_reg.isp_tgl};
        m_next.ext_sync = {m_reg.ext_sync[0], extest_t};
        m_next.act_sync = {m_reg.act_sync[0], t_reg.isp_q};
        // enable is a pin level, so two flops before the pad mux reads it
        m_next.en_sync = {m_reg.en_sync[0], tap_enable};
        m_next.isp_strobe = 1'h0;
        // words are stable in the tck domain from the toggle until the next update
        if (m_reg.upd_sync[2] != m_reg.upd_sync[1])
        begin
            m_next.upd_out = t_reg.upd_out;
            m_next.upd_oe = t_reg.upd_oe;
        end
        if (m_reg.isp_sync[2] != m_reg.isp_sync[1])
        begin
            m_next.isp_data = t_reg.isp_hold;
            m_next.isp_op = t_reg.ir;
            m_next.isp_strobe = 1'h1;
        end
        if (m_reg.ext_sync[1] && m_reg.en_sync[1])
        begin
            m_next.pin_out = m_reg.upd_out;
            m_next.pin_oe = m_reg.upd_oe;
        end
        else
        begin
            m_next.pin_out = core_out;
            m_next.pin_oe = core_oe;
        end
        if (!rst_n)
        begin
            m_next = '0;
        end
    end

    always_ff @(posedge mclk)
    begin
        m_reg <= m_next;
    end

    assign tdo = tap_enable ? tdo_neg_reg : user_tdo_out;
    assign tdo_oe = tap_enable ? tdo_oe_neg_reg : user_tdo_oe;
    assign user_tck_in = m_reg.usr_s2[2];
    assign user_tms_in = m_reg.usr_s2[1];
    assign user_tdi_in = m_reg.usr_s2[0];
    assign core_in = m_reg.pin_s2;
    assign pin_out = m_reg.pin_out;
    assign pin_oe = m_reg.pin_oe;
    assign isp_active = m_reg.act_sync[1];
    assign isp_strobe = m_reg.isp_strobe;
    assign isp_opcode = m_reg.isp_op;
    assign isp_wdata = m_reg.isp_data;

endmodule

//--- verif/bsc_tap_chk.sv
`timescale 1ns/100ps
module bsc_tap_chk #(
    parameter int BSR_LEN = bsc_pkg::BSR_LEN_DEF,
    parameter logic [bsc_pkg::IR_LEN-1:0] ISP_OP_BASE = bsc_pkg::ISP_OP_BASE_DEF,
    parameter logic [bsc_pkg::IR_LEN-1:0] ISP_OP_MASK = bsc_pkg::ISP_OP_MASK_DEF
) (
    // clocks and reset
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic tck,
    // port pins
    input wire logic tms,
    input wire logic tdo,
    input wire logic tdo_oe,
    input wire logic tap_enable,
    input wire logic user_tdo_out,
    input wire logic user_tdo_oe,
    // core and pad drive
    input wire logic [BSR_LEN/bsc_pkg::CELLS_PER_PIN-1:0] core_out,
    input wire logic [BSR_LEN/bsc_pkg::CELLS_PER_PIN-1:0] pin_out,
    // programming handoff
    input wire logic isp_active,
    input wire logic isp_strobe,
    input wire logic [bsc_pkg::IR_LEN-1:0] isp_opcode
);
    import bsc_pkg::*;
    property p_rel_tdo;
        @(posedge mclk) disable iff (!rst_n) !tap_enable |-> tdo == user_tdo_out && tdo_oe == user_tdo_oe;
    endproperty
    a_rel_tdo: assert property (p_rel_tdo) else $error("tdo pin not handed to user");
    // long settle window: the enable level passes two system-clock flops before the pad mux reads it
    property p_core_path;
        @(posedge mclk) disable iff (!rst_n) !tap_enable [*8] |=> pin_out == $past(core_out);
    endproperty
    a_core_path: assert property (p_core_path) else $error("pads not on core path");
    property p_strobe_pulse;
        @(posedge mclk) disable iff (!rst_n) isp_strobe |=> !isp_strobe;
    endproperty
    a_strobe_pulse: assert property (p_strobe_pulse) else $error("handoff strobe too long");
    property p_strobe_mode;
        @(posedge mclk) disable iff (!rst_n) isp_strobe |-> isp_active;
    endproperty
    a_strobe_mode: assert property (p_strobe_mode) else $error("strobe outside programming mode");
    property p_strobe_op;
        @(posedge mclk) disable iff (!rst_n) isp_strobe |-> (isp_opcode & ISP_OP_MASK) == ISP_OP_BASE;
    endproperty
    a_strobe_op: assert property (p_strobe_op) else $error("strobe with foreign opcode");
    property p_op_hold;
        @(posedge mclk) disable iff (!rst_n) !isp_strobe |-> $stable(isp_opcode);
    endproperty
    a_op_hold: assert property (p_op_hold) else $error("handoff opcode moved");
    property p_oe_enter;
        @(negedge tck) disable iff (!rst_n) tap_enable && $past(tap_enable) && $rose(tdo_oe) |-> !$past(tms);
    endproperty
    a_oe_enter: assert property (p_oe_enter) else $error("tdo driven without shift entry");
    property p_oe_leave;
        @(negedge tck) disable iff (!rst_n) tap_enable && $past(tap_enable) && $fell(tdo_oe) |-> $past(tms);
    endproperty
    a_oe_leave: assert property (p_oe_leave) else $error("tdo dropped inside shift");
endmodule
bind bsc_tap_top bsc_tap_chk #(.BSR_LEN(BSR_LEN), .ISP_OP_BASE(ISP_OP_BASE), .ISP_OP_MASK(ISP_OP_MASK)) i_chk (
    .mclk(mclk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdo(tdo), .tdo_oe(tdo_oe), .tap_enable(tap_enable),
    .user_tdo_out(user_tdo_out), .user_tdo_oe(user_tdo_oe), .core_out(core_out), .pin_out(pin_out),
    .isp_active(isp_active), .isp_strobe(isp_strobe), .isp_opcode(isp_opcode)
);

//--- verif/bsc_jtag_host.sv
`timescale 1ns/100ps
module bsc_jtag_host (
    // link pins
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe
);
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // drive just after the fall, take tdo at the rise; tck idles low
    task automatic cyc(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #15;
        tck = 1'b1;
        // an undriven tdo reads as the inverse of its last level
        q = tdo_oe ? tdo : ~tdo;
        #15;
        tck = 1'b0;
    endtask
    // released lines: tms pulled up, tdi shows the inverse of its last bit
    task automatic rest;
        tms = 1'b1;
        tdi = ~tdi;
    endtask
    task automatic idle(input int n);
        logic q;
        #1.7;
        repeat (n) cyc(1'b1, 1'b0, q);
        cyc(1'b0, 1'b0, q);
        rest();
    endtask
    // one scan from idle and back; programming opcodes go the same way
    task automatic scan(input logic ir, input int n, input logic [255:0] din, output logic [255:0] dout);
        logic q;
        dout = '0;
        #1.7;
        cyc(1'b1, 1'b0, q);
        if (ir)
            cyc(1'b1, 1'b0, q);
        cyc(1'b0, 1'b0, q);
        cyc(1'b0, 1'b0, q);
        for (int i = 0; i < n; i++)
        begin
            cyc(i == n - 1, din[i], q);
            dout[i] = q;
        end
        cyc(1'b1, 1'b0, q);
        cyc(1'b0, 1'b0, q);
        rest();
    endtask
    task automatic pins(input logic m, input logic d);
        tms = m;
        tdi = d;
    endtask
endmodule

//--- verif/test_boundary_scan_tap.sv
`timescale 1ns/100ps
module test_boundary_scan_tap;
    import bsc_pkg::*;
    localparam int NPIN = BSR_LEN_DEF / CELLS_PER_PIN;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic tck, tms, tdi, tdo, tdo_oe;
    logic tap_enable = 1'b1;
    logic user_tdo_out = 1'b0;
    logic user_tdo_oe = 1'b0;
    logic user_tck_in, user_tms_in, user_tdi_in;
    logic [NPIN-1:0] core_out = 64'h0123_4567_89ab_cdef;
    logic [NPIN-1:0] core_oe = 64'hffff_0000_f0f0_0f0f;
    logic [NPIN-1:0] pin_in = 64'hf0e1_d2c3_b4a5_9687;
    logic [NPIN-1:0] core_in, pin_out, pin_oe;
    logic [31:0] usercode_value = 32'hc3a5_0f1e;
    logic [31:0] isp_rdata = 32'h2468_ace1;
    logic isp_active, isp_strobe;
    logic [9:0] isp_opcode, seen_op;
    logic [31:0] isp_wdata, seen_wd;
    int errors = 0;
    int checks = 0;
    int cycles = 0;
    int strobes = 0;

    bsc_tap_top i_dut (
        .mclk(mclk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
        .tap_enable(tap_enable), .user_tdo_out(user_tdo_out), .user_tdo_oe(user_tdo_oe),
        .user_tck_in(user_tck_in), .user_tms_in(user_tms_in), .user_tdi_in(user_tdi_in),
        .core_out(core_out), .core_oe(core_oe), .core_in(core_in), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .usercode_value(usercode_value), .isp_rdata(isp_rdata), .isp_active(isp_active),
        .isp_strobe(isp_strobe), .isp_opcode(isp_opcode), .isp_wdata(isp_wdata)
    );
    bsc_jtag_host i_host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));

    always #2.5 mclk = ~mclk;
    // the strobe is one cycle wide, so it is latched here while scans run
    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (isp_strobe === 1'b1)
        begin
            strobes <= strobes + 1;
            seen_op <= isp_opcode;
            seen_wd <= isp_wdata;
        end
        if (cycles == 30000)
        begin
            errors++;
            print_verdict();
        end
    end

    task automatic chk(input string what, input logic [255:0] seen, input logic [255:0] exp);
        checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict;
        if (errors == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    function automatic logic [255:0] cells(input logic [NPIN-1:0] d, input logic [NPIN-1:0] oe, input int sh);
        logic [255:0] v;
        v = '0;
        for (int k = 0; k < NPIN; k++)
        begin
            v[sh + CELLS_PER_PIN * k + CELL_OUT] = d[k];
            v[sh + CELLS_PER_PIN * k + CELL_OE] = oe[k];
        end
        return v;
    endfunction
    function automatic logic [NPIN-1:0] caught(input logic [255:0] q);
        logic [NPIN-1:0] w;
        for (int k = 0; k < NPIN; k++)
            w[k] = q[CELLS_PER_PIN * k + CELL_IN];
        return w;
    endfunction
    // 20-bit scan: capture word first, then the marker back, so length shows
    task automatic ir(input logic [9:0] op);
        logic [255:0] q;
        i_host.scan(1'b1, 2 * IR_LEN, {236'h0, op, 10'h2a5}, q);
        chk("instruction scan", q[19:0], {10'h2a5, IR_CAPTURE_VAL});
    endtask
    task automatic t_idcode;
        logic [255:0] q;
        i_host.scan(1'b0, 64, 256'h9e37_79b9, q);
        chk("idcode after reset", q[31:0], {ID_VERSION_DEF, ID_PART_DEF, ID_MAKER_DEF, 1'b1});
        chk("idcode first bit", q[0], 1'b1);
        ir(OP_IDCODE_DEF);
        i_host.scan(1'b0, 64, 256'h9e37_79b9, q);
        chk("idcode fields", q[31:0], {ID_VERSION_DEF, ID_PART_DEF, ID_MAKER_DEF, 1'b1});
        chk("idcode length", q[63:32], 32'h9e37_79b9);
    endtask
    task automatic t_usercode;
        logic [255:0] q;
        ir(OP_USERCODE_DEF);
        i_host.scan(1'b0, 64, 256'h5aa5_0ff0, q);
        chk("usercode", q[31:0], usercode_value);
        chk("usercode length", q[63:32], 32'h5aa5_0ff0);
    endtask
    task automatic t_boundary;
        logic [255:0] q;
        ir(OP_SAMPLE_DEF);
        i_host.scan(1'b0, BSR_LEN_DEF, cells(64'ha5a5_3c3c_0ff0_9669, 64'h00ff_ff00_1234_5678, 0), q);
        chk("sample capture", caught(q), pin_in);
        repeat (10) @(posedge mclk);
        chk("sample pad drive", {pin_out, pin_oe}, {core_out, core_oe});
        pin_in <= 64'h1e2d_3c4b_5a69_7887;
        ir(OP_EXTEST_DEF);
        repeat (10) @(posedge mclk);
        chk("preload drive", {pin_out, pin_oe}, 128'ha5a5_3c3c_0ff0_9669_00ff_ff00_1234_5678);
        i_host.scan(1'b0, BSR_LEN_DEF + 8, cells(64'h6c6c_9393_ab54_e71e, 64'hffff_0000_0000_0001, 8) | 256'h5c, q);
        chk("extest capture", caught(q), pin_in);
        chk("boundary length", q[BSR_LEN_DEF +: 8], 8'h5c);
        repeat (10) @(posedge mclk);
        chk("extest drive", {pin_out, pin_oe}, 128'h6c6c_9393_ab54_e71e_ffff_0000_0000_0001);
    endtask
    task automatic t_isp;
        logic [255:0] q;
        ir(10'h2a3);
        repeat (10) @(posedge mclk);
        chk("programming mode", isp_active, 1'b1);
        i_host.scan(1'b0, ISP_LEN_DEF, 256'h1357_9bdf, q);
        repeat (10) @(posedge mclk);
        chk("programming readback", q[31:0], isp_rdata);
        chk("programming handoff", {strobes, seen_op, seen_wd}, {32'd1, 10'h2a3, 32'h1357_9bdf});
    endtask
    task automatic t_release;
        // pads on the update stage first, so the core path check means something
        ir(OP_EXTEST_DEF);
        @(posedge mclk);
        tap_enable <= 1'b0;
        user_tdo_out <= 1'b1;
        user_tdo_oe <= 1'b1;
        i_host.pins(1'b0, 1'b1);
        repeat (12) @(posedge mclk);
        chk("released tdo", {tdo, tdo_oe}, 2'b11);
        chk("user pins", {user_tck_in, user_tms_in, user_tdi_in}, 3'b001);
        chk("core path", pin_out, core_out);
        chk("core input", core_in, pin_in);
        tap_enable <= 1'b1;
        user_tdo_oe <= 1'b0;
        i_host.idle(6);
    endtask
    task automatic t_bypass;
        logic [9:0] ops [3] = '{OP_BYPASS_DEF, 10'h123, 10'h3fe};
        logic [255:0] q;
        foreach (ops[k])
        begin
            ir(ops[k]);
            i_host.scan(1'b0, 8, 256'hb4, q);
            chk("bypass path", q[7:0], 8'h68);
        end
        chk("programming mode off", isp_active, 1'b0);
    endtask

    // link runs while reset is held so the link side sees it too
    initial
    begin
        i_host.idle(4);
        @(posedge mclk);
        rst_n <= 1'b1;
        i_host.idle(5);
        t_idcode();
        t_usercode();
        t_boundary();
        t_isp();
        t_release();
        t_bypass();
        print_verdict();
    end
endmodule
